// ==== rtl/llsp_sampler.sv ====
module llsp_sampler #(
    parameter int N_TAGS  = 4,
    parameter int CNT_IDX = 0
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    input  wire logic                      enh_fmt_ok,
    input  wire logic                      disp_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] disp_tag,
    input  wire logic                      disp_store,
    input  wire logic                      disp_prefetch,
    input  wire logic                      cache_acc_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] cache_acc_tag,
    input  wire logic                      ord_blk_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] ord_blk_tag,
    input  wire logic                      blk_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] blk_tag,
    input  wire logic [3:0]                blk_flags,
    input  wire logic                      wb_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] wb_tag,
    input  wire llsp_pkg::llsp_src_t       wb_src,
    input  wire logic                      wb_snoop,
    input  wire logic                      wb_sib_hit,
    input  wire logic                      wb_sib_fwd,
    input  wire logic                      wb_far,
    input  wire logic                      wb_remote,
    input  wire logic                      wb_modified,
    input  wire logic                      ret_valid,
    input  wire logic [$clog2(N_TAGS)-1:0] ret_tag,
    output logic                           sample_valid,
    output logic      [15:0]               sample_inst_lat,
    output logic      [15:0]               sample_cache_lat,
    output logic      [3:0]                sample_src,
    output logic      [3:0]                sample_info,
    output logic      [31:0]               counter_value
);
    localparam int TW = $clog2(N_TAGS);

    default clocking dflt_cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    if (N_TAGS < 2 || (N_TAGS & (N_TAGS - 1)) != 0) begin : g_bad_tags
        $error("N_TAGS must be a power of two of at least 2");
    end
    if (CNT_IDX < 0 || CNT_IDX > 31) begin : g_bad_idx
        $error("CNT_IDX out of range");
    end

    typedef struct packed {
        logic [31:0]              evtsel;
        logic [15:0]              thresh;
        logic [31:0]              grpcfg;
        logic [31:0]              smpen;
        logic [31:0]              counter;
        logic [31:0]              rdata;
        logic [N_TAGS-1:0]        busy;
        logic [N_TAGS-1:0]        pf;
        logic [N_TAGS-1:0]        inst_run;
        logic [N_TAGS-1:0]        cache_run;
        logic [N_TAGS-1:0][15:0]  inst_lat;
        logic [N_TAGS-1:0][15:0]  cache_lat;
        logic [N_TAGS-1:0][3:0]   src;
        logic [N_TAGS-1:0][3:0]   info;
        logic                     s_valid;
        logic [15:0]              s_inst;
        logic [15:0]              s_cache;
        logic [3:0]               s_src;
        logic [3:0]               s_info;
    } llsp_state_t;

    llsp_state_t st_ff;
    llsp_state_t nxt_st;

    // ****************************************
    // Source encoding
    // ****************************************
    function automatic logic [3:0] llsp_encode(input llsp_pkg::llsp_src_t s, input logic snoop,
                                               input logic sib_hit, input logic sib_fwd,
                                               input logic far, input logic remote,
                                               input logic modified);
        logic [3:0] code;
        code = llsp_pkg::DS_UNKNOWN;
        unique case (s)
            llsp_pkg::SRC_L1:     code = llsp_pkg::DS_L1;
            llsp_pkg::SRC_FB:     code = llsp_pkg::DS_MERGE;
            llsp_pkg::SRC_L2:     code = llsp_pkg::DS_L2;
            llsp_pkg::SRC_L3: begin
                if (!snoop)        code = llsp_pkg::DS_L3;
                else if (sib_fwd)  code = llsp_pkg::DS_XC_FWD;
                else if (sib_hit)  code = llsp_pkg::DS_XC_HIT;
                else               code = llsp_pkg::DS_XC_MISS;
            end
            llsp_pkg::SRC_MEM: begin
                if (far) code = remote ? llsp_pkg::DS_RFAR : llsp_pkg::DS_LFAR;
                else     code = remote ? llsp_pkg::DS_RNEAR : llsp_pkg::DS_LNEAR;
            end
            llsp_pkg::SRC_RCACHE: code = modified ? llsp_pkg::DS_RMOD : llsp_pkg::DS_RFWD;
            llsp_pkg::SRC_IO:     code = llsp_pkg::DS_IO;
            llsp_pkg::SRC_UC:     code = llsp_pkg::DS_UC;
            default:              code = llsp_pkg::DS_UNKNOWN;
        endcase
        return code;
    endfunction : llsp_encode

    logic ev_sel;
    logic smp_on;
    logic ret_hit;
    logic ret_elig;
    assign ev_sel   = (st_ff.evtsel[15:0] == llsp_pkg::LD_LAT_EVENT) && enh_fmt_ok;
    assign smp_on   = ev_sel && st_ff.smpen[CNT_IDX] && st_ff.grpcfg[llsp_pkg::GRP_MEMINFO_BIT];
    assign ret_hit  = ret_valid && st_ff.busy[ret_tag];
    assign ret_elig = ret_hit && (st_ff.inst_lat[ret_tag] > st_ff.thresh);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s_valid = 1'b0;
        nxt_st.rdata = 32'h0000_0000;
        // Latency grows each cycle until writeback, holding at 16'hFFFF; cache latency skips ordering-block cycles
        for (int i = 0; i < N_TAGS; i++) begin
            if (st_ff.inst_run[i] && st_ff.inst_lat[i] != 16'hFFFF)
                nxt_st.inst_lat[i] = st_ff.inst_lat[i] + 16'h0001;
            if (st_ff.cache_run[i] && st_ff.cache_lat[i] != 16'hFFFF &&
                !(ord_blk_valid && ord_blk_tag == TW'(i)))
                nxt_st.cache_lat[i] = st_ff.cache_lat[i] + 16'h0001;
        end
        if (cache_acc_valid && st_ff.busy[cache_acc_tag] && st_ff.inst_run[cache_acc_tag] &&
            !st_ff.cache_run[cache_acc_tag] && st_ff.cache_lat[cache_acc_tag] == 16'h0000) begin
            nxt_st.cache_run[cache_acc_tag] = 1'b1;
            nxt_st.cache_lat[cache_acc_tag] = 16'h0001;
        end
        if (blk_valid && st_ff.busy[blk_tag])
            nxt_st.info[blk_tag] = st_ff.info[blk_tag] | blk_flags;
        if (wb_valid && st_ff.busy[wb_tag] && st_ff.inst_run[wb_tag]) begin
            nxt_st.inst_run[wb_tag]  = 1'b0;
            nxt_st.cache_run[wb_tag] = 1'b0;
            nxt_st.src[wb_tag] = llsp_encode(wb_src, wb_snoop, wb_sib_hit, wb_sib_fwd,
                                             wb_far, wb_remote, wb_modified);
        end
        // Retire frees the entry; sample only for eligible loads
        if (ret_hit) begin
            nxt_st.busy[ret_tag]      = 1'b0;
            nxt_st.inst_run[ret_tag]  = 1'b0;
            nxt_st.cache_run[ret_tag] = 1'b0;
            if (ret_elig && ev_sel)
                nxt_st.counter = st_ff.counter + 32'h0000_0001;
            if (ret_elig && smp_on) begin
                nxt_st.s_valid = 1'b1;
                nxt_st.s_inst  = st_ff.inst_lat[ret_tag];
                nxt_st.s_info  = st_ff.info[ret_tag];
                nxt_st.s_src   = st_ff.pf[ret_tag] ? llsp_pkg::DS_L1 : st_ff.src[ret_tag];
                nxt_st.s_cache = st_ff.pf[ret_tag] ? llsp_pkg::L1_HIT_LAT : st_ff.cache_lat[ret_tag];
            end
        end
        // Stores never take an entry, so they neither count nor sample
        if (disp_valid && !disp_store && !nxt_st.busy[disp_tag]) begin
            nxt_st.busy[disp_tag]      = 1'b1;
            nxt_st.pf[disp_tag]        = disp_prefetch;
            nxt_st.inst_run[disp_tag]  = 1'b1;
            nxt_st.inst_lat[disp_tag]  = 16'h0001;
            nxt_st.cache_run[disp_tag] = 1'b0;
            nxt_st.cache_lat[disp_tag] = 16'h0000;
            nxt_st.src[disp_tag]       = llsp_pkg::DS_UNKNOWN;
            nxt_st.info[disp_tag]      = 4'h0;
        end
        // Software write wins over a same-cycle increment
        if (reg_wr) begin
            unique case (reg_addr)
                llsp_pkg::OFS_EVTSEL:  nxt_st.evtsel  = reg_wdata;
                llsp_pkg::OFS_THRESH:  nxt_st.thresh  = reg_wdata[15:0];
                llsp_pkg::OFS_GRPCFG:  nxt_st.grpcfg  = reg_wdata;
                llsp_pkg::OFS_SMPEN:   nxt_st.smpen   = reg_wdata;
                llsp_pkg::OFS_COUNTER: nxt_st.counter = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                llsp_pkg::OFS_EVTSEL:  nxt_st.rdata = st_ff.evtsel;
                llsp_pkg::OFS_THRESH:  nxt_st.rdata = {16'h0000, st_ff.thresh};
                llsp_pkg::OFS_GRPCFG:  nxt_st.rdata = st_ff.grpcfg;
                llsp_pkg::OFS_SMPEN:   nxt_st.rdata = st_ff.smpen;
                llsp_pkg::OFS_COUNTER: nxt_st.rdata = st_ff.counter;
                llsp_pkg::OFS_STATUS:  nxt_st.rdata = {22'h000000, st_ff.busy[N_TAGS-1:0] != '0,
                                                       ev_sel, smp_on, 1'b0, 4'(st_ff.busy),
                                                       2'h0};
                default:               nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff        <= '0;
            st_ff.evtsel <= llsp_pkg::RST_EVTSEL;
            st_ff.thresh <= llsp_pkg::RST_THRESH;
            st_ff.grpcfg <= llsp_pkg::RST_GRPCFG;
            st_ff.smpen  <= llsp_pkg::RST_SMPEN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata        = st_ff.rdata;
    assign sample_valid     = st_ff.s_valid;
    assign sample_inst_lat  = st_ff.s_inst;
    assign sample_cache_lat = st_ff.s_cache;
    assign sample_src       = st_ff.s_src;
    assign sample_info      = st_ff.s_info;
    assign counter_value    = st_ff.counter;

    // ****************************************
    // Checks
    // ****************************************
    sequence elig_retire_s;
        ret_elig && ev_sel && !reg_wr;
    endsequence
    sequence store_disp_s;
        disp_valid && disp_store && !st_ff.busy[disp_tag] && !(disp_tag == ret_tag && ret_hit);
    endsequence

    cnt_inc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        elig_retire_s |=> counter_value == $past(counter_value) + 32'h0000_0001)
        else $error("counter missed an eligible load");
    cnt_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(ret_elig && ev_sel) && !reg_wr |=> $stable(counter_value))
        else $error("counter moved without an eligible load");
    store_skip_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        store_disp_s |=> !st_ff.busy[$past(disp_tag)])
        else $error("store took a tracking entry");
    thr_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        sample_valid |-> sample_inst_lat > $past(st_ff.thresh))
        else $error("sample at or below threshold");
    pf_src_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        ret_elig && smp_on && st_ff.pf[ret_tag] |=>
        sample_src == llsp_pkg::DS_L1 && sample_cache_lat == llsp_pkg::L1_HIT_LAT)
        else $error("prefetch not reported as first-level hit");
    inst_grow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_ff.inst_run[0] && st_ff.inst_lat[0] != 16'hFFFF && !(ret_valid && ret_tag == '0) |=>
        st_ff.inst_lat[0] == $past(st_ff.inst_lat[0]) + 16'h0001)
        else $error("instruction latency did not advance");
    cache_pause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_ff.cache_run[0] && ord_blk_valid && ord_blk_tag == '0 &&
        !(ret_valid && ret_tag == '0) && !(disp_valid && disp_tag == '0) |=> $stable(st_ff.cache_lat[0]))
        else $error("cache latency counted an ordering block");
    src_l2_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wb_valid && wb_tag == '0 && st_ff.inst_run[0] && wb_src == llsp_pkg::SRC_L2 &&
        !(ret_valid && ret_tag == '0) |=> st_ff.src[0] == llsp_pkg::DS_L2)
        else $error("second-level hit mis-encoded");
    fmt_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !enh_fmt_ok |=> !sample_valid)
        else $error("sample without enhanced format");

    // ****************************************
    // Per-load checks
    // ****************************************
    sequence wb_live_s;
        wb_valid && st_ff.inst_run[wb_tag] && !(ret_valid && ret_tag == wb_tag);
    endsequence
    sequence new_load_s;
        disp_valid && !disp_store && !st_ff.busy[disp_tag];
    endsequence

    lat_start_a: assert property (
        new_load_s |=> st_ff.inst_lat[$past(disp_tag)] == 16'h0001)
        else $error("instruction latency did not start at one");
    lat_stop_a: assert property (
        wb_live_s |=> !st_ff.inst_run[$past(wb_tag)] && !st_ff.cache_run[$past(wb_tag)])
        else $error("latency kept running after writeback");
    src_merge_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_FB) |=> st_ff.src[$past(wb_tag)] == llsp_pkg::DS_MERGE)
        else $error("merged miss mis-encoded");
    src_l3_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_L3 && !wb_snoop) |=>
        st_ff.src[$past(wb_tag)] == llsp_pkg::DS_L3)
        else $error("clean third-level hit mis-encoded");
    src_sib_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_L3 && wb_snoop && wb_sib_fwd) |=>
        st_ff.src[$past(wb_tag)] == llsp_pkg::DS_XC_FWD)
        else $error("sibling forward mis-encoded");
    src_mem_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_MEM && !wb_far && wb_remote) |=>
        st_ff.src[$past(wb_tag)] == llsp_pkg::DS_RNEAR)
        else $error("remote near memory mis-encoded");
    src_rfwd_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_RCACHE && !wb_modified) |=>
        st_ff.src[$past(wb_tag)] == llsp_pkg::DS_RFWD)
        else $error("remote forward mis-encoded");
    src_io_a: assert property (
        wb_live_s and (wb_src == llsp_pkg::SRC_IO) |=> st_ff.src[$past(wb_tag)] == llsp_pkg::DS_IO)
        else $error("input/output source mis-encoded");
    info_keep_a: assert property (
        blk_valid && st_ff.busy[blk_tag] && !(ret_valid && ret_tag == blk_tag) |=>
        (st_ff.info[$past(blk_tag)] & $past(blk_flags)) == $past(blk_flags))
        else $error("access block flag lost");
    cnt_fmt_a: assert property (
        !enh_fmt_ok && !reg_wr |=> $stable(counter_value))
        else $error("counter moved without enhanced format");
    smp_cause_a: assert property (
        sample_valid |-> $past(ret_elig && smp_on))
        else $error("sample without an eligible retire");
endmodule : llsp_sampler

// ==== rtl/llsp_pkg.sv ====
package llsp_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  OFS_EVTSEL   = 8'h00;
    localparam logic [7:0]  OFS_THRESH   = 8'h04;
    localparam logic [7:0]  OFS_GRPCFG   = 8'h08;
    localparam logic [7:0]  OFS_SMPEN    = 8'h0C;
    localparam logic [7:0]  OFS_COUNTER  = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [15:0] LD_LAT_EVENT = 16'h01CD;
    localparam int          GRP_MEMINFO_BIT = 0;
    localparam logic [31:0] RST_EVTSEL   = 32'h0000_0000;
    localparam logic [15:0] RST_THRESH   = 16'h0003;
    localparam logic [31:0] RST_GRPCFG   = 32'h0000_0000;
    localparam logic [31:0] RST_SMPEN    = 32'h0000_0000;
    localparam logic [15:0] L1_HIT_LAT   = 16'h0005;
    // ****************************************
    // Data source codes
    // ****************************************
    localparam logic [3:0] DS_UNKNOWN  = 4'h0;
    localparam logic [3:0] DS_L1       = 4'h1;
    localparam logic [3:0] DS_MERGE    = 4'h2;
    localparam logic [3:0] DS_L2       = 4'h3;
    localparam logic [3:0] DS_L3       = 4'h4;
    localparam logic [3:0] DS_XC_MISS  = 4'h5;
    localparam logic [3:0] DS_XC_HIT   = 4'h6;
    localparam logic [3:0] DS_XC_FWD   = 4'h7;
    localparam logic [3:0] DS_LFAR     = 4'h8;
    localparam logic [3:0] DS_RFAR     = 4'h9;
    localparam logic [3:0] DS_LNEAR    = 4'hA;
    localparam logic [3:0] DS_RNEAR    = 4'hB;
    localparam logic [3:0] DS_RFWD     = 4'hC;
    localparam logic [3:0] DS_RMOD     = 4'hD;
    localparam logic [3:0] DS_IO       = 4'hE;
    localparam logic [3:0] DS_UC       = 4'hF;
    typedef enum logic [3:0] {
        SRC_UNKNOWN = 4'h0,
        SRC_L1      = 4'h1,
        SRC_FB      = 4'h2,
        SRC_L2      = 4'h3,
        SRC_L3      = 4'h4,
        SRC_MEM     = 4'h5,
        SRC_RCACHE  = 4'h6,
        SRC_IO      = 4'h7,
        SRC_UC      = 4'h8
    } llsp_src_t;
endpackage : llsp_pkg

// ==== tb/llsp_sw_model.sv ====
// ****************************************
// Configuring software on the register port
// ****************************************
module llsp_sw_model (
    input  wire logic        core_clk,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Released lines flip, so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask : rd

    // Upper event bits stay zero: mask and invert fields cleared
    task automatic configure(input logic [15:0] evt, input logic [15:0] thr,
                             input logic [31:0] grp, input logic [31:0] smp);
        logic [15:0] t;
        t = (thr == 16'h0000) ? 16'h0001 : thr;
        wr(llsp_pkg::OFS_GRPCFG, grp);
        wr(llsp_pkg::OFS_THRESH, {16'h0000, t});
        wr(llsp_pkg::OFS_EVTSEL, {16'h0000, evt});
        wr(llsp_pkg::OFS_SMPEN, smp);
    endtask : configure
endmodule : llsp_sw_model

// ==== tb/tb_load_latency_sampler.sv ====
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_load_latency_sampler;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Signals
    // ****************************************
    logic core_clk, reset_n, enh_fmt_ok, reg_wr, reg_rd, sample_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, counter_value, seed, exp_cnt, d;
    logic disp_valid, disp_store, disp_prefetch, cache_acc_valid, ord_blk_valid, blk_valid, wb_valid, ret_valid;
    logic [1:0]  disp_tag, cache_acc_tag, ord_blk_tag, blk_tag, wb_tag, ret_tag;
    logic [3:0]  blk_flags, sample_src, sample_info;
    logic [5:0]  wb_bits;
    logic [15:0] sample_inst_lat, sample_cache_lat, thr;
    llsp_pkg::llsp_src_t wb_src;
    logic evt_on, grp_on, smp_on;
    int   fail_count, n_compared;

    llsp_sampler #(.N_TAGS(4), .CNT_IDX(0)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enh_fmt_ok(enh_fmt_ok),
        .disp_valid(disp_valid), .disp_tag(disp_tag), .disp_store(disp_store),
        .disp_prefetch(disp_prefetch), .cache_acc_valid(cache_acc_valid), .cache_acc_tag(cache_acc_tag),
        .ord_blk_valid(ord_blk_valid), .ord_blk_tag(ord_blk_tag), .blk_valid(blk_valid),
        .blk_tag(blk_tag), .blk_flags(blk_flags), .wb_valid(wb_valid), .wb_tag(wb_tag),
        .wb_src(wb_src), .wb_snoop(wb_bits[5]), .wb_sib_hit(wb_bits[4]), .wb_sib_fwd(wb_bits[3]),
        .wb_far(wb_bits[2]), .wb_remote(wb_bits[1]), .wb_modified(wb_bits[0]),
        .ret_valid(ret_valid), .ret_tag(ret_tag), .sample_valid(sample_valid),
        .sample_inst_lat(sample_inst_lat), .sample_cache_lat(sample_cache_lat),
        .sample_src(sample_src), .sample_info(sample_info), .counter_value(counter_value));

    llsp_sw_model sw_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ****************************************
    // Expectation helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [3:0] exp_src(input llsp_pkg::llsp_src_t s, input logic [5:0] b);
        case (s)
            llsp_pkg::SRC_L1:     return 4'h1;
            llsp_pkg::SRC_FB:     return 4'h2;
            llsp_pkg::SRC_L2:     return 4'h3;
            llsp_pkg::SRC_L3:     return !b[5] ? 4'h4 : b[3] ? 4'h7 : b[4] ? 4'h6 : 4'h5;
            llsp_pkg::SRC_MEM:    return {2'b10, !b[2], b[1]};
            llsp_pkg::SRC_RCACHE: return b[0] ? 4'hD : 4'hC;
            llsp_pkg::SRC_IO:     return 4'hE;
            llsp_pkg::SRC_UC:     return 4'hF;
            default:              return 4'h0;
        endcase
    endfunction : exp_src
    // ****************************************
    // Load driver and checks
    // ****************************************
    // Access edge doubles as a re-dispatch, which must not restart latency
    task automatic run_load(input logic [1:0] tag, input logic st, input logic pf, input int w, input int a,
                            input int b, input logic [3:0] fl, input llsp_pkg::llsp_src_t src,
                            input logic [5:0] bits);
        logic ok;
        for (int i = 0; i <= w + 2; i++) begin
            @(posedge core_clk);
            disp_valid      <= (i == 0) || (i == a);
            cache_acc_valid <= (i == a);
            blk_valid       <= (i == a);
            ord_blk_valid   <= (i > a) && (i <= a + b);
            wb_valid        <= (i == w);
            ret_valid       <= (i == w + 2);
            {disp_tag, cache_acc_tag, ord_blk_tag, blk_tag, wb_tag, ret_tag} <= {6{tag}};
            {disp_store, disp_prefetch, blk_flags, wb_bits} <= {st, pf, fl, bits};
            wb_src          <= src;
        end
        @(posedge core_clk);
        {disp_valid, cache_acc_valid, blk_valid, ord_blk_valid, wb_valid, ret_valid} <= 6'h00;
        ok = !st && (16'(w + 1) > thr) && evt_on && (enh_fmt_ok === 1'b1);
        if (ok)
            exp_cnt = exp_cnt + 32'h1;
        #1;
        `CHK(sample_valid, ok && grp_on && smp_on)
        `CHK(counter_value, exp_cnt)
        if (ok && grp_on && smp_on) begin
            `CHK(sample_inst_lat, 16'(w + 1))
            `CHK(sample_cache_lat, pf ? llsp_pkg::L1_HIT_LAT : 16'(w - a + 1 - b))
            `CHK(sample_src, pf ? llsp_pkg::DS_L1 : exp_src(src, bits))
            `CHK(sample_info, fl)
        end
        @(posedge core_clk);
        #1;
        `CHK(sample_valid, 1'b0)
    endtask : run_load

    task automatic rand_load();
        int w, a;
        logic [31:0] r;
        r = rnd();
        w = 2 + int'(r[7:0]) % 11;
        a = 1 + int'(r[15:8]) % (w - 1);
        run_load(r[17:16], r[20:18] == 3'h0, r[23:21] == 3'h0, w, a, int'(r[31:24]) % (w - a),
                 r[27:24], llsp_pkg::llsp_src_t'(int'(r[31:28]) % 9), r[29:24]);
    endtask : rand_load

    task automatic set_cfg(input logic [15:0] e, input logic [15:0] t, input logic g, input logic s);
        evt_on = (e == llsp_pkg::LD_LAT_EVENT);
        thr    = (t == 16'h0000) ? 16'h0001 : t;
        grp_on = g;
        smp_on = s;
        sw_u.configure(e, t, 32'(g) << llsp_pkg::GRP_MEMINFO_BIT, 32'(s));
    endtask : set_cfg

    task automatic end_of_test();
        $display("fail_count %0d n_compared %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset_n, enh_fmt_ok, disp_valid, disp_store, disp_prefetch, cache_acc_valid} = 6'h00;
        {ord_blk_valid, blk_valid, wb_valid, ret_valid, wb_bits, blk_flags} = 14'h0000;
        {disp_tag, cache_acc_tag, ord_blk_tag, blk_tag, wb_tag, ret_tag} = 12'h000;
        wb_src = llsp_pkg::SRC_UNKNOWN;
        {fail_count, n_compared} = 64'h0;
        {seed, exp_cnt, thr, evt_on, grp_on, smp_on} = {32'd23390, 32'h0, 16'h0003, 3'b000};
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        sw_u.rd(llsp_pkg::OFS_THRESH, d);
        `CHK(d, {16'h0000, llsp_pkg::RST_THRESH})
        sw_u.rd(8'hFC, d);
        `CHK(d, 32'h0000_0000)
        enh_fmt_ok <= 1'b1;
        set_cfg(llsp_pkg::LD_LAT_EVENT, 16'h0005, 1'b1, 1'b1);
        sw_u.rd(llsp_pkg::OFS_STATUS, d);
        `CHK(d, 32'h0000_0180)
        run_load(2'h0, 1'b0, 1'b0, 4, 1, 0, 4'h5, llsp_pkg::SRC_L2, 6'h00);
        run_load(2'h2, 1'b0, 1'b0, 5, 2, 1, 4'hA, llsp_pkg::SRC_L3, 6'h28);
        run_load(2'h3, 1'b1, 1'b0, 9, 3, 2, 4'hF, llsp_pkg::SRC_IO, 6'h00);
        run_load(2'h0, 1'b0, 1'b1, 8, 2, 3, 4'h3, llsp_pkg::SRC_MEM, 6'h04);
        for (int k = 0; k < 9; k++)
            run_load(2'(k), 1'b0, 1'b0, 9, 2, 1, 4'(k), llsp_pkg::llsp_src_t'(k), 6'(k * 7));
        set_cfg(16'h01CC, 16'h0002, 1'b1, 1'b1);
        run_load(2'h1, 1'b0, 1'b0, 9, 2, 0, 4'h1, llsp_pkg::SRC_UC, 6'h00);
        set_cfg(llsp_pkg::LD_LAT_EVENT, 16'h0002, 1'b0, 1'b1);
        run_load(2'h2, 1'b0, 1'b0, 9, 2, 0, 4'h2, llsp_pkg::SRC_L1, 6'h00);
        enh_fmt_ok <= 1'b0;
        run_load(2'h3, 1'b0, 1'b0, 9, 2, 0, 4'h2, llsp_pkg::SRC_L1, 6'h00);
        enh_fmt_ok <= 1'b1;
        sw_u.wr(llsp_pkg::OFS_COUNTER, 32'h0000_0100);
        exp_cnt = 32'h0000_0100;
        for (int k = 0; k < 60; k++) begin
            if (k % 10 == 0) begin
                d = rnd();
                set_cfg(llsp_pkg::LD_LAT_EVENT, 16'(1 + int'(d[3:0]) % 10), 1'b1, d[8] | d[9]);
            end
            rand_load();
        end
        sw_u.rd(llsp_pkg::OFS_COUNTER, d);
        `CHK(d, exp_cnt)
        end_of_test();
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
endmodule : tb_load_latency_sampler
